// >>> adc_trig_result.sv
/*
 Converter trigger select and result formatting with an AXI4-Lite slave.
 Assumes a converter core that takes a one-cycle start and answers with a
 one-cycle done carrying the 10-bit result; trigger sources on aclk.
*/
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
//
// Contract
// - A 5-bit trigger select where 0 is no trigger and 1..17 pick timers, comparators, cells, units.
// - Every selected trigger source acts only on its low-to-high transition.
// - Timer overflow sources fire when that timer raises its own interrupt flag.
// - Left-justified, result bits 9..2 fill the whole high byte.
// - Left-justified, result bits 1..0 go to bits 7..6 of the low byte.
// - Right-justified, result bits 9..8 go to bits 1..0 of the high byte.
// - Select bits 7..5 read zero and the select field resets to zero.
// - Right-justified, result bits 7..0 fill the whole low byte.
`timescale 1ns/1ns
module adc_trig_result (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [adc_trig_pkg::ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [adc_trig_pkg::ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Trigger sources
    input wire logic [adc_trig_pkg::NUM_SRC:1] trig_src,
    // Converter core
    output logic conv_start,
    input wire adc_trig_pkg::conv_result_s conv_result
);
    import adc_trig_pkg::*;

    logic [SEL_W-1:0] trig_sel_ff;
    logic [7:0] res_high_ff;
    logic [7:0] res_low_ff;
    logic enable_ff;
    logic justify_ff;
    logic busy_ff;
    logic conv_start_ff;
    logic aw_full_ff;
    logic w_full_ff;
    logic [ADDR_W-1:0] waddr_ff;
    logic [31:0] wdata_ff;
    logic [3:0] wstrb_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
        reg_hit = (a == OFF_TRIG_SEL) || (a == OFF_RES_HIGH) || (a == OFF_RES_LOW)
            || (a == OFF_CTRL);
    endfunction

    // Write channel
    wire aw_take = awvalid & awready_ff;
    wire w_take = wvalid & wready_ff;
    wire do_write = aw_full_ff & w_full_ff & ~bvalid_ff;
    wire nxt_aw_full = (aw_full_ff | aw_take) & ~do_write;
    wire nxt_w_full = (w_full_ff | w_take) & ~do_write;
    wire nxt_bvalid = do_write | (bvalid_ff & ~bready);
    wire wr_b0 = do_write & wstrb_ff[0];
    wire wr_trig = wr_b0 && waddr_ff == OFF_TRIG_SEL;
    wire wr_high = wr_b0 && waddr_ff == OFF_RES_HIGH;
    wire wr_low = wr_b0 && waddr_ff == OFF_RES_LOW;
    wire wr_ctrl = wr_b0 && waddr_ff == OFF_CTRL;
    wire sw_go = wr_ctrl & wdata_ff[CTRL_GO_BIT];

    // Read channel
    wire ar_take = arvalid & arready_ff;
    wire nxt_rvalid = ar_take | (rvalid_ff & ~rready);
    wire [31:0] ctrl_rd = {29'h0000000, busy_ff, justify_ff, enable_ff};
    // Upper select bits are not stored and read as zero
    wire [31:0] trig_rd = {27'h0000000, trig_sel_ff};
    wire [31:0] nxt_rdata = (araddr == OFF_TRIG_SEL) ? trig_rd :
                            (araddr == OFF_RES_HIGH) ? {24'h000000, res_high_ff} :
                            (araddr == OFF_RES_LOW) ? {24'h000000, res_low_ff} :
                            (araddr == OFF_CTRL) ? ctrl_rd : 32'h00000000;

    // Trigger and start
    logic hw_fire;
    trig_edge_select u_edge (
        .aclk(aclk),
        .aresetn(aresetn),
        .src(trig_src),
        .sel(trig_sel_ff),
        .fire(hw_fire)
    );
    // Hardware and software starts share one path and one enable
    wire nxt_start = enable_ff & ~busy_ff & (hw_fire | sw_go);

    // Result formatting; unused bits load as zero
    wire [RES_W-1:0] res = conv_result.data;
    wire [7:0] fmt_high = justify_ff ? {6'h00, res[9:8]} : res[9:2];
    wire [7:0] fmt_low = justify_ff ? res[7:0] : {res[1:0], 6'h00};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_ff <= 1'b0;
            w_full_ff <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else begin
            aw_full_ff <= nxt_aw_full;
            w_full_ff <= nxt_w_full;
            awready_ff <= ~nxt_aw_full & ~nxt_bvalid;
            wready_ff <= ~nxt_w_full & ~nxt_bvalid;
            bvalid_ff <= nxt_bvalid;
            if (do_write) begin
                bresp_ff <= reg_hit(waddr_ff) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (aw_take) begin
            waddr_ff <= awaddr;
        end
        if (w_take) begin
            wdata_ff <= wdata;
            wstrb_ff <= wstrb;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= RESP_OKAY;
        end else begin
            arready_ff <= ~nxt_rvalid;
            rvalid_ff <= nxt_rvalid;
            if (ar_take) begin
                rdata_ff <= nxt_rdata;
                rresp_ff <= reg_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_sel_ff <= TRIG_SEL_RST;
            enable_ff <= 1'b0;
            justify_ff <= 1'b0;
        end else if (wr_trig) begin
            trig_sel_ff <= wdata_ff[SEL_W-1:0];
        end else if (wr_ctrl) begin
            enable_ff <= wdata_ff[CTRL_ENABLE_BIT];
            justify_ff <= wdata_ff[CTRL_JUSTIFY_BIT];
        end
    end

    // A finished conversion beats a software write in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_high_ff <= RES_RST;
            res_low_ff <= RES_RST;
        end else if (conv_result.done) begin
            res_high_ff <= fmt_high;
            res_low_ff <= fmt_low;
        end else begin
            if (wr_high) begin
                res_high_ff <= wdata_ff[7:0];
            end
            if (wr_low) begin
                res_low_ff <= wdata_ff[7:0];
            end
        end
    end

    // Busy blocks restarts so an edge mid-conversion cannot corrupt the core
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_ff <= 1'b0;
            conv_start_ff <= 1'b0;
        end else begin
            conv_start_ff <= nxt_start;
            busy_ff <= nxt_start | (busy_ff & ~conv_result.done);
        end
    end

    assign awready = awready_ff;
    assign wready = wready_ff;
    assign bvalid = bvalid_ff;
    assign bresp = bresp_ff;
    assign arready = arready_ff;
    assign rvalid = rvalid_ff;
    assign rdata = rdata_ff;
    assign rresp = rresp_ff;
    assign conv_start = conv_start_ff;
endmodule

// >>> adc_trig_pkg.sv
/*
 Shared constants and types for the converter trigger and result block.
 Assumes a 32-bit AXI4-Lite register bus and a 10-bit converter core.
*/
package adc_trig_pkg;
    localparam int ADDR_W = 4;
    localparam int RES_W = 10;
    localparam int SEL_W = 5;
    localparam int NUM_SRC = 17;
    // Register byte addresses
    localparam logic [ADDR_W-1:0] OFF_TRIG_SEL = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_RES_HIGH = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_RES_LOW = 4'h8;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 4'hC;
    // Control register fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_JUSTIFY_BIT = 1;
    localparam int CTRL_GO_BIT = 2;
    // Reset values, select code limits and bus response codes
    localparam logic [SEL_W-1:0] TRIG_SEL_RST = 5'h00;
    localparam logic [7:0] RES_RST = 8'h00;
    localparam logic [SEL_W-1:0] SEL_NONE = 5'h00;
    localparam logic [SEL_W-1:0] SEL_LAST = 5'h11;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic done;
        logic [RES_W-1:0] data;
    } conv_result_s;
endpackage

// >>> trig_edge_select.sv
/*
 Edge detector and source selector for automatic conversion starts.
 Assumes all sources are synchronous to aclk (internal peripherals).
*/
`timescale 1ns/1ns
module trig_edge_select (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Sources and selection
    input wire logic [adc_trig_pkg::NUM_SRC:1] src,
    input wire logic [adc_trig_pkg::SEL_W-1:0] sel,
    // Result
    output logic fire
);
    import adc_trig_pkg::*;

    wire [NUM_SRC:0] rise;

    assign rise[0] = 1'b0;
    genvar g;
    generate
        for (g = 1; g <= NUM_SRC; g++) begin : g_src
            logic prev_ff;
            // Every source kept tracked, so a select change cannot fake an edge
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    prev_ff <= 1'b1;
                end else begin
                    prev_ff <= src[g];
                end
            end
            // Low-to-high only; overflow sources are their flag levels
            assign rise[g] = src[g] & ~prev_ff;
        end
    endgenerate

    // Code zero and codes above the last source never fire
    assign fire = (sel != SEL_NONE) && (sel <= SEL_LAST) && rise[sel];
endmodule

// >>> adc_trig_result_sva.sv
/* Port assertions for the trigger and result block.
   Assumes the bind below; sees top-level ports only. */
`timescale 1ns/1ns
module adc_trig_result_sva (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus
    input wire logic awvalid,
    input wire logic awready,
    input wire logic [adc_trig_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [31:0] wdata,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [adc_trig_pkg::ADDR_W-1:0] araddr,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    // Converter side
    input wire logic [adc_trig_pkg::NUM_SRC:1] trig_src,
    input wire logic conv_start,
    input wire adc_trig_pkg::conv_result_s conv_result
);
    import adc_trig_pkg::*;
    logic busy_ff;
    logic [ADDR_W-1:0] raddr_ff;
    logic [NUM_SRC:1] hist_ff;
    logic aw_ctrl_ff;
    logic w_go_ff;
    wire rise = |(trig_src & ~hist_ff);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // History starts high so a level held over reset is no edge
    always_ff @(posedge aclk) begin
        hist_ff <= aresetn ? trig_src : '1;
        if (arvalid && arready) raddr_ff <= araddr;
        if (awvalid && awready) aw_ctrl_ff <= (awaddr == OFF_CTRL);
        if (wvalid && wready) w_go_ff <= wdata[CTRL_GO_BIT];
        if (!aresetn) busy_ff <= 1'b0;
        else if (conv_start) busy_ff <= 1'b1;
        else if (conv_result.done) busy_ff <= 1'b0;
    end
    a_start_pulse: assert property (conv_start |=> !conv_start [*3])
        else $error("start longer than one cycle");
    // A software go starts with the write response, so it is no source edge
    a_start_cause: assert property (conv_start |-> $past(rise) || ($rose(bvalid) && aw_ctrl_ff && w_go_ff))
        else $error("start without a source edge or software go");
    a_busy_nostart: assert property (busy_ff |-> !conv_start)
        else $error("start while converting");
    a_sel_upper: assert property (rvalid && raddr_ff == OFF_TRIG_SEL |-> rdata[31:5] == 27'h0)
        else $error("select upper bits not zero");
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read answer late");
    a_ar_refused: assert property (rvalid |-> !arready)
        else $error("read taken while answer pending");
    a_b_stands: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");
    a_r_stands: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped");
    cover property (conv_start);
    cover property (conv_result.done);
    cover property (rvalid && raddr_ff == OFF_RES_LOW);
    cover property (conv_start && $rose(bvalid));
endmodule
bind adc_trig_result adc_trig_result_sva chk (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .bvalid(bvalid),
    .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .trig_src(trig_src),
    .conv_start(conv_start), .conv_result(conv_result));

// >>> conv_core_model.sv
/* Converter core model answering each start after LAT cycles.
   Assumes one-cycle starts on aclk. */
`timescale 1ns/1ns
module conv_core_model #(
    parameter int LAT = 5
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Start and sample
    input wire logic conv_start,
    input wire logic [adc_trig_pkg::RES_W-1:0] sample,
    // Answer
    output adc_trig_pkg::conv_result_s conv_result
);
    import adc_trig_pkg::*;
    int cnt_ff;
    // Data scrambled outside done so stale values are never trusted
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_ff <= 0;
            conv_result <= '0;
        end else begin
            conv_result.done <= (cnt_ff == 1);
            conv_result.data <= (cnt_ff == 1) ? sample : ~conv_result.data;
            cnt_ff <= conv_start ? LAT : (cnt_ff != 0 ? cnt_ff - 1 : 0);
        end
    end
endmodule

// >>> adc_trig_result_bench.sv
/* Self-checking bench for the trigger and result block.
   Assumes the core model answers every start. */
`timescale 1ns/1ns
module adc_trig_result_bench;
    import adc_trig_pkg::*;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rd;
    logic [NUM_SRC:1] trig_src = '0;
    logic [RES_W-1:0] sample = '0;
    logic conv_start, awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    conv_result_s conv_result;
    int miscompares = 0, checked = 0, starts = 0;
    always #5 aclk = ~aclk;
    always @(posedge aclk) if (conv_start === 1'b1) starts++;
    adc_trig_result uut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .trig_src(trig_src), .conv_start(conv_start),
        .conv_result(conv_result));
    conv_core_model #(.LAT(5)) core (.aclk(aclk), .aresetn(aresetn), .conv_start(conv_start),
        .sample(sample), .conv_result(conv_result));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
        input logic [1:0] er = RESP_OKAY);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Only the watchdog ends a wait that never gets its answer
        while (bvalid !== 1'b1) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        bready <= 1'b0;
        chk("bresp", 32'(er), 32'(bresp));
    endtask
    task automatic rdr(input logic [ADDR_W-1:0] a, input logic [1:0] er);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (rvalid !== 1'b1) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end
        rready <= 1'b0;
        rd = rdata;
        chk("rresp", 32'(er), 32'(rresp));
    endtask
    // Level held past the conversion must not start a second one
    task automatic pulse(input int s, input int n);
        int s0;
        s0 = starts;
        @(posedge aclk);
        trig_src[s] <= 1'b1;
        repeat (14) @(posedge aclk);
        trig_src[s] <= 1'b0;
        chk("starts", 32'(n), 32'(starts - s0));
    endtask
    task automatic t_regs();
        rdr(OFF_TRIG_SEL, RESP_OKAY);
        chk("sel reset", 32'h0, rd);
        wr(OFF_TRIG_SEL, 32'hFF);
        rdr(OFF_TRIG_SEL, RESP_OKAY);
        chk("sel field", 32'h1F, rd);
        rdr(4'h6, RESP_SLVERR);
        chk("unmapped data", 32'h0, rd);
        $display("t_regs done");
    endtask
    task automatic t_left();
        logic [RES_W-1:0] v;
        wr(OFF_CTRL, 32'h1);
        for (int s = 1; s <= NUM_SRC; s++) begin
            v = 10'h35A ^ RES_W'(s);
            sample <= v;
            wr(OFF_TRIG_SEL, 32'(s));
            pulse(s % NUM_SRC + 1, 0);
            pulse(s, 1);
            rdr(OFF_RES_HIGH, RESP_OKAY);
            chk("left high", 32'(v[9:2]), rd);
            rdr(OFF_RES_LOW, RESP_OKAY);
            chk("left low", 32'({v[1:0], 6'h00}), rd);
        end
        $display("t_left done");
    endtask
    task automatic t_right();
        sample <= 10'h2A7;
        wr(OFF_CTRL, 32'h3);
        pulse(17, 1);
        rdr(OFF_RES_HIGH, RESP_OKAY);
        chk("right high", 32'h2, rd);
        rdr(OFF_RES_LOW, RESP_OKAY);
        chk("right low", 32'hA7, rd);
        wr(OFF_CTRL, 32'h0);
        pulse(17, 0);
        wr(OFF_CTRL, 32'h1);
        wr(OFF_TRIG_SEL, 32'h0);
        pulse(1, 0);
        $display("t_right done");
    endtask
    // Software start and result byte writes share the register path
    task automatic t_soft();
        int s0;
        wr(OFF_RES_HIGH, 32'h5C);
        rdr(OFF_RES_HIGH, RESP_OKAY);
        chk("high written", 32'h5C, rd);
        wr(4'h6, 32'h1, RESP_SLVERR);
        wr(OFF_TRIG_SEL, 32'h12);
        pulse(1, 0);
        s0 = starts;
        sample <= 10'h1C3;
        wr(OFF_CTRL, 32'h7);
        repeat (12) @(posedge aclk);
        chk("soft start", 32'h1, 32'(starts - s0));
        rdr(OFF_RES_HIGH, RESP_OKAY);
        chk("soft high", 32'h1, rd);
        rdr(OFF_RES_LOW, RESP_OKAY);
        chk("soft low", 32'hC3, rd);
        $display("t_soft done");
    endtask
    task automatic end_sim();
        $display("Checks %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs();
        t_left();
        t_right();
        t_soft();
        end_sim();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        end_sim();
    end
endmodule
